// ===== common/ssta_pkg.sv
// ssta_pkg: constants, opcodes and register map of the subtract/swap/direction datapath
// assumes an AXI4-Lite master and a decoder/file bank on the same core clock
// What this block does
// - plain subtract: file minus working register
// - destination bit 0 to wreg, 1 to file
// - carry, digit carry clear when wreg exceeds
// - borrow subtract also removes inverted carry
// - swap exchanges nibbles, flags untouched
// - operand 5,6,7 loads direction A,B,C
package ssta_pkg;
    localparam int unsigned DATA_W   = 8;
    localparam int unsigned FADDR_W  = 7;
    localparam int unsigned AXI_AW   = 8;

    typedef enum logic [1:0] {
        SSTA_OP_SUB    = 2'h0,
        SSTA_OP_SUBB   = 2'h1,
        SSTA_OP_SWAP   = 2'h3,
        SSTA_OP_DIR    = 2'h2
    } ssta_op_t;

    // direction register selectors
    localparam logic [6:0] DIR_SEL_A = 7'h05;
    localparam logic [6:0] DIR_SEL_B = 7'h06;
    localparam logic [6:0] DIR_SEL_C = 7'h07;

    // register byte offsets
    localparam logic [7:0] REG_FLAGS = 8'h00;
    localparam logic [7:0] REG_WREG  = 8'h04;
    localparam logic [7:0] REG_DIR_A = 8'h08;
    localparam logic [7:0] REG_DIR_B = 8'h0c;
    localparam logic [7:0] REG_DIR_C = 8'h10;
    localparam logic [7:0] REG_COUNT = 8'h14;

    // flag register fields
    localparam int unsigned FLAG_C_BIT     = 0;
    localparam int unsigned FLAG_DIGIT_BIT = 1;
    localparam int unsigned FLAG_Z_BIT     = 2;

    // reset values
    localparam logic [7:0] WREG_RST = 8'h00;
    localparam logic [7:0] DIR_RST  = 8'hff;
    localparam logic [2:0] FLAGS_RST = 3'h0;

    localparam logic [1:0] AXI_OKAY   = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage

// ===== hdl/ssta_sub_unit.sv
// ssta_sub_unit: combinational 8-bit subtractor with borrow-in, carry and digit carry out
// assumes inputs are stable within the cycle
`timescale 1ns/100ps
module ssta_sub_unit (
    // operands
    input  wire logic [7:0] minuend_i,
    input  wire logic [7:0] subtrahend_i,
    input  wire logic       borrow_in_i,
    // results
    output logic      [7:0] diff_o,
    output logic            carry_o,
    output logic            digit_carry_o
);
    logic [8:0] full;
    logic [4:0] low;

    always_comb begin
        // carry 1 means no borrow: wreg plus borrow not above file
        full          = {1'b0, minuend_i} - {1'b0, subtrahend_i} - {8'h00, borrow_in_i};
        low           = {1'b0, minuend_i[3:0]} - {1'b0, subtrahend_i[3:0]} - {4'h0, borrow_in_i};
        diff_o        = full[7:0];
        carry_o       = ~full[8];
        digit_carry_o = ~low[4];
    end
endmodule

// ===== hdl/ssta_alu.sv
// ssta_alu: execution datapath for subtract, subtract-borrow, nibble swap and direction load
// assumes decoder and file bank on core_clk_i; one instruction per enabled cycle with exec_valid_i high
//
// Decided for this implementation: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/100ps
module ssta_alu (
    // clock, reset, enable
    input  wire logic        core_clk_i,
    input  wire logic        rstn_i,
    input  wire logic        clk_en_i,
    // instruction from decoder
    input  wire logic        exec_valid_i,
    input  wire logic [1:0]  exec_op_i,
    input  wire logic [6:0]  exec_faddr_i,
    input  wire logic        exec_dest_i,
    input  wire logic [7:0]  file_rdata_i,
    // file register write back
    output logic             file_we_o,
    output logic      [6:0]  file_waddr_o,
    output logic      [7:0]  file_wdata_o,
    // working register, flags, direction registers
    output logic      [7:0]  wreg_o,
    output logic             carry_flag_o,
    output logic             digit_carry_flag_o,
    output logic             zero_flag_o,
    output logic      [7:0]  port_a_direction_o,
    output logic      [7:0]  port_b_direction_o,
    output logic      [7:0]  port_c_direction_o,
    // axi4-lite write
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic      [1:0]  s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic      [31:0] s_axi_rdata,
    output logic      [1:0]  s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    // datapath state
    logic [7:0]  wreg, next_wreg;
    logic [2:0]  flags, next_flags;
    logic [7:0]  dir_a, next_dir_a, dir_b, next_dir_b, dir_c, next_dir_c;
    logic        f_we, next_f_we;
    logic [6:0]  f_waddr, next_f_waddr;
    logic [7:0]  f_wdata, next_f_wdata;
    logic [7:0]  exec_cnt, next_exec_cnt;
    // bus state
    logic        aw_held, next_aw_held, w_held, next_w_held;
    logic [7:0]  aw_addr, next_aw_addr;
    logic [31:0] w_data, next_w_data;
    logic [3:0]  w_strb, next_w_strb;
    logic        bvalid, next_bvalid;
    logic [1:0]  bresp, next_bresp;
    logic        rvalid, next_rvalid;
    logic [1:0]  rresp, next_rresp;
    logic [31:0] rdata, next_rdata;
    logic        awrdy, next_awrdy, wrdy, next_wrdy, arrdy, next_arrdy;

    logic [7:0]  diff, swapped, result;
    logic        sub_c, sub_digit, is_sub, borrow;
    logic        wr_go, rd_go;

    assign is_sub  = (exec_op_i == ssta_pkg::SSTA_OP_SUB) || (exec_op_i == ssta_pkg::SSTA_OP_SUBB);
    // borrow is the inverted carry, only for the borrow form
    assign borrow  = (exec_op_i == ssta_pkg::SSTA_OP_SUBB) & ~flags[ssta_pkg::FLAG_C_BIT];
    assign swapped = {file_rdata_i[3:0], file_rdata_i[7:4]};
    assign result  = is_sub ? diff : swapped;

    ssta_sub_unit u_sub (
        .minuend_i     (file_rdata_i),
        .subtrahend_i  (wreg),
        .borrow_in_i   (borrow),
        .diff_o        (diff),
        .carry_o       (sub_c),
        .digit_carry_o (sub_digit)
    );

    assign wr_go = aw_held & w_held & ~bvalid;
    assign rd_go = s_axi_arvalid & ~rvalid;

    always_comb begin
        next_wreg     = wreg;
        next_flags    = flags;
        next_dir_a    = dir_a;
        next_dir_b    = dir_b;
        next_dir_c    = dir_c;
        next_f_we     = 1'b0;
        next_f_waddr  = f_waddr;
        next_f_wdata  = f_wdata;
        next_exec_cnt = exec_cnt;
        // software writes steer working register, flags and direction registers
        if (wr_go && w_strb[0]) begin
            if (aw_addr == ssta_pkg::REG_FLAGS) begin
                next_flags = w_data[2:0];
            end else if (aw_addr == ssta_pkg::REG_WREG) begin
                next_wreg = w_data[7:0];
            end else if (aw_addr == ssta_pkg::REG_DIR_A) begin
                next_dir_a = w_data[7:0];
            end else if (aw_addr == ssta_pkg::REG_DIR_B) begin
                next_dir_b = w_data[7:0];
            end else if (aw_addr == ssta_pkg::REG_DIR_C) begin
                next_dir_c = w_data[7:0];
            end
        end
        // instruction execution takes priority over a bus write
        if (exec_valid_i) begin
            next_exec_cnt = exec_cnt + 8'h01;
            case (exec_op_i)
                ssta_pkg::SSTA_OP_SUB, ssta_pkg::SSTA_OP_SUBB, ssta_pkg::SSTA_OP_SWAP: begin
                    if (exec_dest_i) begin
                        next_f_we    = 1'b1;
                        next_f_waddr = exec_faddr_i;
                        next_f_wdata = result;
                    end else begin
                        next_wreg = result;
                    end
                    if (is_sub) begin
                        next_flags[ssta_pkg::FLAG_C_BIT]     = sub_c;
                        next_flags[ssta_pkg::FLAG_DIGIT_BIT] = sub_digit;
                        next_flags[ssta_pkg::FLAG_Z_BIT]     = (diff == 8'h00);
                    end else begin
                        next_flags = flags;
                    end
                end
                default: begin
                    if (exec_faddr_i == ssta_pkg::DIR_SEL_A) begin
                        next_dir_a = wreg;
                    end else if (exec_faddr_i == ssta_pkg::DIR_SEL_B) begin
                        next_dir_b = wreg;
                    end else if (exec_faddr_i == ssta_pkg::DIR_SEL_C) begin
                        next_dir_c = wreg;
                    end
                    next_flags = flags;
                end
            endcase
        end
    end

    always_comb begin
        next_aw_held = aw_held;
        next_aw_addr = aw_addr;
        next_w_held  = w_held;
        next_w_data  = w_data;
        next_w_strb  = w_strb;
        next_bvalid  = bvalid;
        next_bresp   = bresp;
        next_rvalid  = rvalid;
        next_rresp   = rresp;
        next_rdata   = rdata;
        if (s_axi_awvalid && !aw_held) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_held) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (wr_go) begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            if (aw_addr <= ssta_pkg::REG_COUNT && aw_addr[1:0] == 2'h0) begin
                next_bresp = ssta_pkg::AXI_OKAY;
            end else begin
                next_bresp = ssta_pkg::AXI_SLVERR;
            end
        end
        if (bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (rd_go) begin
            next_rvalid = 1'b1;
            next_rresp  = ssta_pkg::AXI_OKAY;
            next_rdata  = 32'h0000_0000;
            if (s_axi_araddr == ssta_pkg::REG_FLAGS) begin
                next_rdata[2:0] = flags;
            end else if (s_axi_araddr == ssta_pkg::REG_WREG) begin
                next_rdata[7:0] = wreg;
            end else if (s_axi_araddr == ssta_pkg::REG_DIR_A) begin
                next_rdata[7:0] = dir_a;
            end else if (s_axi_araddr == ssta_pkg::REG_DIR_B) begin
                next_rdata[7:0] = dir_b;
            end else if (s_axi_araddr == ssta_pkg::REG_DIR_C) begin
                next_rdata[7:0] = dir_c;
            end else if (s_axi_araddr == ssta_pkg::REG_COUNT) begin
                next_rdata[7:0] = exec_cnt;
            end else begin
                next_rresp = ssta_pkg::AXI_SLVERR;
            end
        end else if (rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        // ready outputs registered from the next holding state
        next_awrdy = ~next_aw_held;
        next_wrdy  = ~next_w_held;
        next_arrdy = ~next_rvalid;
    end

    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            wreg     <= ssta_pkg::WREG_RST;
            flags    <= ssta_pkg::FLAGS_RST;
            dir_a    <= ssta_pkg::DIR_RST;
            dir_b    <= ssta_pkg::DIR_RST;
            dir_c    <= ssta_pkg::DIR_RST;
            f_we     <= 1'b0;
            f_waddr  <= 7'h00;
            f_wdata  <= 8'h00;
            exec_cnt <= 8'h00;
            aw_held  <= 1'b0;
            aw_addr  <= 8'h00;
            w_held   <= 1'b0;
            w_data   <= 32'h0000_0000;
            w_strb   <= 4'h0;
            bvalid   <= 1'b0;
            bresp    <= 2'h0;
            rvalid   <= 1'b0;
            rresp    <= 2'h0;
            rdata    <= 32'h0000_0000;
            awrdy    <= 1'b1;
            wrdy     <= 1'b1;
            arrdy    <= 1'b1;
        end else if (clk_en_i) begin
            wreg     <= next_wreg;
            flags    <= next_flags;
            dir_a    <= next_dir_a;
            dir_b    <= next_dir_b;
            dir_c    <= next_dir_c;
            f_we     <= next_f_we;
            f_waddr  <= next_f_waddr;
            f_wdata  <= next_f_wdata;
            exec_cnt <= next_exec_cnt;
            aw_held  <= next_aw_held;
            aw_addr  <= next_aw_addr;
            w_held   <= next_w_held;
            w_data   <= next_w_data;
            w_strb   <= next_w_strb;
            bvalid   <= next_bvalid;
            bresp    <= next_bresp;
            rvalid   <= next_rvalid;
            rresp    <= next_rresp;
            rdata    <= next_rdata;
            awrdy    <= next_awrdy;
            wrdy     <= next_wrdy;
            arrdy    <= next_arrdy;
        end
    end

    assign file_we_o          = f_we;
    assign file_waddr_o       = f_waddr;
    assign file_wdata_o       = f_wdata;
    assign wreg_o             = wreg;
    assign carry_flag_o       = flags[ssta_pkg::FLAG_C_BIT];
    assign digit_carry_flag_o = flags[ssta_pkg::FLAG_DIGIT_BIT];
    assign zero_flag_o        = flags[ssta_pkg::FLAG_Z_BIT];
    assign port_a_direction_o = dir_a;
    assign port_b_direction_o = dir_b;
    assign port_c_direction_o = dir_c;
    assign s_axi_awready      = awrdy;
    assign s_axi_wready       = wrdy;
    assign s_axi_bvalid       = bvalid;
    assign s_axi_bresp        = bresp;
    assign s_axi_arready      = arrdy;
    assign s_axi_rvalid       = rvalid;
    assign s_axi_rresp        = rresp;
    assign s_axi_rdata        = rdata;
endmodule

// ===== bench/ssta_file_bank.sv
// ssta_file_bank: file register bank model facing the datapath
// assumes one-cycle write pulses on core_clk_i; read is combinational
`timescale 1ns/100ps
module ssta_file_bank (
    // clock
    input  wire logic       core_clk_i,
    // read port
    input  wire logic [6:0] raddr_i,
    output logic      [7:0] rdata_o,
    // write port
    input  wire logic       we_i,
    input  wire logic [6:0] waddr_i,
    input  wire logic [7:0] wdata_i
);
    logic [7:0] mem [128];
    initial begin
        for (int i = 0; i < 128; i++) begin
            mem[i] = 8'(i);
        end
    end
    assign rdata_o = mem[raddr_i];
    always @(posedge core_clk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
    end
endmodule

// ===== bench/ssta_alu_assertions.sv
// ssta_alu_checker: port-level checks of the datapath
// assumes a bind into ssta_alu; single clock, sync active-low reset
`timescale 1ns/100ps
module ssta_alu_checker (
    // clock, reset, instruction
    input wire logic       core_clk_i,
    input wire logic       rstn_i,
    input wire logic       clk_en_i,
    input wire logic       exec_valid_i,
    input wire logic [1:0] exec_op_i,
    input wire logic [6:0] exec_faddr_i,
    input wire logic       exec_dest_i,
    input wire logic [7:0] file_rdata_i,
    // results
    input wire logic       file_we_o,
    input wire logic [6:0] file_waddr_o,
    input wire logic [7:0] file_wdata_o,
    input wire logic [7:0] wreg_o,
    input wire logic       carry_flag_o,
    input wire logic       digit_carry_flag_o,
    input wire logic       zero_flag_o,
    input wire logic [7:0] port_a_direction_o,
    input wire logic [7:0] port_b_direction_o,
    input wire logic [7:0] port_c_direction_o
);
    logic       go;
    logic       sb;
    logic       brw;
    logic [2:0] fl;
    logic [8:0] full;
    logic [4:0] low;
    assign go   = clk_en_i && exec_valid_i;
    assign sb   = go && exec_op_i <= ssta_pkg::SSTA_OP_SUBB;
    assign brw  = exec_op_i == ssta_pkg::SSTA_OP_SUBB && !carry_flag_o;
    assign fl   = {zero_flag_o, digit_carry_flag_o, carry_flag_o};
    assign full = {1'b0, file_rdata_i} - {1'b0, wreg_o} - {8'h00, brw};
    assign low  = {1'b0, file_rdata_i[3:0]} - {1'b0, wreg_o[3:0]} - {4'h0, brw};
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);
    sub_diff_a: assert property (sb && !exec_op_i[0]
        |=> ($past(exec_dest_i) ? file_wdata_o : wreg_o) == $past(file_rdata_i) - $past(wreg_o))
        else $error("bad difference");
    dest_route_a: assert property (go && exec_op_i != ssta_pkg::SSTA_OP_DIR
        |=> file_we_o == $past(exec_dest_i)
        && (!file_we_o || file_waddr_o == $past(exec_faddr_i)))
        else $error("bad destination");
    sub_carry_a: assert property (sb |=> carry_flag_o == !$past(full[8])
        && digit_carry_flag_o == !$past(low[4])) else $error("bad carry flags");
    borrow_diff_a: assert property (sb && exec_op_i[0]
        |=> ($past(exec_dest_i) ? file_wdata_o : wreg_o) == $past(full[7:0]))
        else $error("bad borrow difference");
    swap_keep_a: assert property (go && exec_op_i == ssta_pkg::SSTA_OP_SWAP
        |=> $stable(fl) && ($past(exec_dest_i) ? file_wdata_o : wreg_o)
        == {$past(file_rdata_i[3:0]), $past(file_rdata_i[7:4])}) else $error("bad swap");
    dir_load_a: assert property (go && exec_op_i == ssta_pkg::SSTA_OP_DIR
        && exec_faddr_i inside {[5:7]} |=> $stable(fl) && !file_we_o && $past(wreg_o)
        == ($past(exec_faddr_i) == ssta_pkg::DIR_SEL_A ? port_a_direction_o
        : $past(exec_faddr_i) == ssta_pkg::DIR_SEL_B ? port_b_direction_o
        : port_c_direction_o)) else $error("bad direction load");
    dir_refuse_a: assert property (go && exec_op_i == ssta_pkg::SSTA_OP_DIR
        && !(exec_faddr_i inside {[5:7]}) |=> $stable({port_a_direction_o,
        port_b_direction_o, port_c_direction_o})) else $error("direction changed");
    zero_flag_a: assert property (sb |=> zero_flag_o == ($past(full[7:0]) == 8'h00))
        else $error("bad zero flag");
endmodule
bind ssta_alu ssta_alu_checker i_ssta_alu_checker (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
    .clk_en_i(clk_en_i), .exec_valid_i(exec_valid_i), .exec_op_i(exec_op_i),
    .exec_faddr_i(exec_faddr_i), .exec_dest_i(exec_dest_i), .file_rdata_i(file_rdata_i),
    .file_we_o(file_we_o), .file_waddr_o(file_waddr_o), .file_wdata_o(file_wdata_o),
    .wreg_o(wreg_o), .carry_flag_o(carry_flag_o), .digit_carry_flag_o(digit_carry_flag_o),
    .zero_flag_o(zero_flag_o), .port_a_direction_o(port_a_direction_o),
    .port_b_direction_o(port_b_direction_o), .port_c_direction_o(port_c_direction_o));

// ===== bench/ssta_alu_bench.sv
// ssta_alu_bench: directed tests through the exec port and the register bus
// assumes the file bank model answers reads within the cycle
`timescale 1ns/100ps
module ssta_alu_bench;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        ev = 1'b0;
    logic        ed = 1'b0;
    logic [1:0]  eop = 2'h0;
    logic [6:0]  efa = 7'h00;
    logic [7:0]  awa = 8'h00;
    logic [7:0]  ara = 8'h00;
    logic [31:0] wd = 32'h0;
    logic        awv = 1'b0;
    logic        wv = 1'b0;
    logic        br = 1'b0;
    logic        arv = 1'b0;
    logic        rr = 1'b0;
    logic        ce = 1'b1;
    logic [7:0]  frd, fwd, wro, pa, pb, pc, w, r;
    logic [6:0]  fwa, wa;
    logic        fwe, cf, dcf, zf, awr, wr, bv, arr, rv, we;
    logic [1:0]  bre, rre;
    logic [31:0] rd;
    logic [7:0]  m [128];
    logic [7:0]  d [3];
    logic [2:0]  fl;
    int          n_mismatch, comparisons, nt, n_exec;
    ssta_alu i_ssta_alu (.core_clk_i(clk), .rstn_i(rstn), .clk_en_i(ce), .exec_valid_i(ev),
        .exec_op_i(eop), .exec_faddr_i(efa), .exec_dest_i(ed), .file_rdata_i(frd),
        .file_we_o(fwe), .file_waddr_o(fwa), .file_wdata_o(fwd), .wreg_o(wro),
        .carry_flag_o(cf), .digit_carry_flag_o(dcf), .zero_flag_o(zf), .port_a_direction_o(pa),
        .port_b_direction_o(pb), .port_c_direction_o(pc), .s_axi_awaddr(awa),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bre), .s_axi_bvalid(bv),
        .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rd), .s_axi_rresp(rre), .s_axi_rvalid(rv), .s_axi_rready(rr));
    ssta_file_bank i_ssta_file_bank (.core_clk_i(clk), .raddr_i(efa), .rdata_o(frd),
        .we_i(fwe), .waddr_i(fwa), .wdata_i(fwd));
    always #12.5 clk = ~clk;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        awa <= a;
        wd <= {24'h0, v};
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        do begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wr) wv <= 1'b0;
        end while (!bv);
        br <= 1'b0;
        chk(bre, ssta_pkg::AXI_OKAY);
    endtask
    task automatic axi_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge clk);
        ara <= a;
        arv <= 1'b1;
        rr <= 1'b1;
        do begin
            @(posedge clk);
            if (arr) arv <= 1'b0;
        end while (!rv);
        rr <= 1'b0;
        chk(rd, e);
        chk(rre, er);
    endtask
    task automatic step(input ssta_pkg::ssta_op_t op, input logic [6:0] fa, input logic dt);
        logic [8:0] full;
        logic [4:0] lo;
        logic       b;
        b = op == ssta_pkg::SSTA_OP_SUBB && !fl[0];
        full = {1'b0, m[fa]} - {1'b0, w} - {8'h00, b};
        lo = {1'b0, m[fa][3:0]} - {1'b0, w[3:0]} - {4'h0, b};
        r = op == ssta_pkg::SSTA_OP_SWAP ? {m[fa][3:0], m[fa][7:4]} : full[7:0];
        we = dt && op != ssta_pkg::SSTA_OP_DIR;
        wa = fa;
        if (op <= ssta_pkg::SSTA_OP_SUBB) fl = {full[7:0] == 8'h00, !lo[4], !full[8]};
        if (op == ssta_pkg::SSTA_OP_DIR && fa inside {[5:7]}) d[fa - 7'h05] = w;
        else if (we) m[fa] = r;
        else if (op != ssta_pkg::SSTA_OP_DIR) w = r;
        n_exec++;
        @(posedge clk);
        ev <= 1'b1;
        eop <= op;
        efa <= fa;
        ed <= dt;
    endtask
    task automatic fin();
        @(posedge clk);
        ev <= 1'b0;
        #1;
        chk(wro, w);
        chk({zf, dcf, cf}, fl);
        chk({pc, pb, pa}, {d[2], d[1], d[0]});
        chk(fwe, we);
        if (we) chk({fwa, fwd}, {wa, r});
        nt++;
        $display("test %0d done", nt);
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clk);
        n_mismatch++;
        give_verdict();
    end
    initial begin
        for (int i = 0; i < 128; i++) m[i] = 8'(i);
        d = '{default: 8'hff};
        w = 8'h00;
        fl = 3'h0;
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            axi_rd(8'(4 * i), (i inside {[2:4]}) ? 32'hff : 32'h0,
                i == 6 ? ssta_pkg::AXI_SLVERR : ssta_pkg::AXI_OKAY);
        end
        axi_wr(ssta_pkg::REG_WREG, 8'h03);
        w = 8'h03;
        step(ssta_pkg::SSTA_OP_SUB, 7'h0a, 1'b1);
        fin();
        step(ssta_pkg::SSTA_OP_SUBB, 7'h0a, 1'b0);
        fin();
        axi_wr(ssta_pkg::REG_FLAGS, 8'h00);
        fl = 3'h0;
        step(ssta_pkg::SSTA_OP_SUBB, 7'h04, 1'b1);
        fin();
        axi_wr(ssta_pkg::REG_WREG, 8'h07);
        w = 8'h07;
        step(ssta_pkg::SSTA_OP_SUB, 7'h0a, 1'b0);
        fin();
        step(ssta_pkg::SSTA_OP_SWAP, 7'h5a, 1'b0);
        fin();
        // enable low holds a pending instruction; it runs once when enable returns
        ce <= 1'b0;
        step(ssta_pkg::SSTA_OP_SUB, 7'h10, 1'b0);
        repeat (2) @(posedge clk);
        ce <= 1'b1;
        fin();
        step(ssta_pkg::SSTA_OP_SWAP, 7'h04, 1'b1);
        step(ssta_pkg::SSTA_OP_SUB, 7'h20, 1'b0);
        step(ssta_pkg::SSTA_OP_SUBB, 7'h30, 1'b1);
        fin();
        for (int i = 4; i < 9; i++) begin
            axi_wr(ssta_pkg::REG_WREG, 8'(17 * i));
            w = 8'(17 * i);
            step(ssta_pkg::SSTA_OP_DIR, 7'(i), 1'b1);
            fin();
        end
        for (int i = 0; i < 3; i++) axi_rd(8'(8 + 4 * i), {24'h0, d[i]}, 2'h0);
        axi_rd(ssta_pkg::REG_FLAGS, {29'h0, fl}, ssta_pkg::AXI_OKAY);
        axi_rd(ssta_pkg::REG_COUNT, 32'(n_exec), ssta_pkg::AXI_OKAY);
        give_verdict();
    end
endmodule
